// >>> mpc_pkg.sv
package cmd_pkg;

  // first-edge pattern on ca[4:0] with cs high
  localparam logic [4:0] CMD_R1_CA  = 5'h00;
  localparam logic [4:0] CAS2_R1_CA = 5'h12;

  // full seven-bit training operand codes
  localparam logic [6:0] OP_RD_FIFO   = 7'h41;
  localparam logic [6:0] OP_RD_DQ_CAL = 7'h43;
  localparam logic [6:0] OP_WR_FIFO   = 7'h47;
  localparam logic [6:0] OP_OSC_START = 7'h4B;
  localparam logic [6:0] OP_OSC_STOP  = 7'h4D;
  localparam logic [6:0] OP_ZQ_START  = 7'h4F;
  localparam logic [6:0] OP_ZQ_LATCH  = 7'h51;

  localparam logic [4:0] SIXTEEN_BEAT_BURST = 5'h10;
  localparam logic [4:0] NO_BURST           = 5'h00;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_CMD_R2   = 4'h2,
    ST_WAIT_CAS = 4'h4,
    ST_CAS_R2   = 4'h8
  } state_t;

  typedef enum logic [7:0] {
    K_RSVD      = 8'h00,
    K_NOP       = 8'h01,
    K_RD_FIFO   = 8'h02,
    K_RD_DQ_CAL = 8'h04,
    K_WR_FIFO   = 8'h08,
    K_OSC_START = 8'h10,
    K_OSC_STOP  = 8'h20,
    K_ZQ_START  = 8'h40,
    K_ZQ_LATCH  = 8'h80
  } kind_t;

  function automatic logic is_data_op(input kind_t k);
    is_data_op = (k == K_RD_FIFO) || (k == K_RD_DQ_CAL) ||
                 (k == K_WR_FIFO);
  endfunction : is_data_op

  function automatic logic is_fifo_op(input kind_t k);
    is_fifo_op = (k == K_RD_FIFO) || (k == K_WR_FIFO);
  endfunction : is_fifo_op

endpackage : cmd_pkg

// >>> operand_classifier.sv
module operand_classifier (
  // assembled operand
  input  wire logic [6:0]      command_operand_bits,
  // decoded kind, one-hot, all zero (K_RSVD) for reserved codes
  output cmd_pkg::kind_t       kind
);
  import cmd_pkg::*;

  wire logic op6 = command_operand_bits[6];

  assign kind = !op6                                   ? K_NOP       :
                (command_operand_bits == OP_RD_FIFO)   ? K_RD_FIFO   :
                (command_operand_bits == OP_RD_DQ_CAL) ? K_RD_DQ_CAL :
                (command_operand_bits == OP_WR_FIFO)   ? K_WR_FIFO   :
                (command_operand_bits == OP_OSC_START) ? K_OSC_START :
                (command_operand_bits == OP_OSC_STOP)  ? K_OSC_STOP  :
                (command_operand_bits == OP_ZQ_START)  ? K_ZQ_START  :
                (command_operand_bits == OP_ZQ_LATCH)  ? K_ZQ_LATCH  :
                                                         K_RSVD;

endmodule : operand_classifier

// >>> dram_multi_purpose_cmd_decoder.sv
module dram_multi_purpose_cmd_decoder (
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           sys_rst,
  // command/address pins
  input  wire logic           cs,
  input  wire logic [5:0]     ca,
  // executed operations, one-hot pulses
  output cmd_pkg::kind_t      exec_ff,
  // latency reference for data-moving ops
  output logic                latency_anchor_ff,
  output logic [4:0]          burst_beats_ff,
  // status pulses
  output logic                reserved_seen_ff,
  output logic                sequence_error_ff,
  output logic                cas_operand_error_ff
);
  import cmd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state

  state_t       state_ff;
  state_t       nxt_state;
  logic         op6_ff;
  kind_t        pending_ff;
  kind_t        nxt_pending;
  kind_t        nxt_exec;
  kind_t        kind;
  logic         nxt_anchor;
  logic [4:0]   nxt_beats;
  logic         nxt_reserved;
  logic         nxt_seq_err;
  logic         nxt_cas_err;

  //////////////////////////////////////////////////////////////////////////
  // decode

  wire logic cmd_r1  = cs && (ca[4:0] == CMD_R1_CA);
  wire logic cas_r1  = cs && (ca[4:0] == CAS2_R1_CA);
  wire logic in_idle = (state_ff == ST_IDLE);
  wire logic in_r2   = (state_ff == ST_CMD_R2);
  wire logic in_wait = (state_ff == ST_WAIT_CAS);
  wire logic in_cas2 = (state_ff == ST_CAS_R2);

  operand_classifier u_classifier (
    .command_operand_bits ({op6_ff, ca}),
    .kind                 (kind)
  );

  wire logic r2_data   = in_r2 && is_data_op(kind);
  wire logic r2_alone  = in_r2 && (kind != K_RSVD) && !r2_data;
  wire logic r2_rsvd   = in_r2 && (kind == K_RSVD);
  wire logic wait_bad  = in_wait && cs && !cas_r1;
  wire logic wait_good = in_wait && cas_r1;

  assign nxt_state = in_idle && cmd_r1 ? ST_CMD_R2   :
                     r2_data           ? ST_WAIT_CAS :
                     in_r2             ? ST_IDLE     :
                     wait_good         ? ST_CAS_R2   :
                     wait_bad          ? ST_IDLE     :
                     in_cas2           ? ST_IDLE     :
                                         state_ff;

  assign nxt_pending = r2_data ? kind : (in_cas2 ? K_RSVD : pending_ff);
  // stand-alone ops fire at once; data ops wait for column command
  assign nxt_exec    = r2_alone ? kind :
                       in_cas2  ? pending_ff : K_RSVD;
  assign nxt_anchor  = in_cas2;
  assign nxt_beats   = in_cas2 && is_fifo_op(pending_ff) ?
                       SIXTEEN_BEAT_BURST : NO_BURST;
  assign nxt_reserved = r2_rsvd;
  assign nxt_seq_err  = wait_bad;
  assign nxt_cas_err  = in_cas2 && (cs || (ca != 6'h00));

  //////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff   <= ST_IDLE;
      op6_ff     <= 1'b0;
      pending_ff <= K_RSVD;
    end else begin
      state_ff   <= nxt_state;
      op6_ff     <= (in_idle && cmd_r1) ? ca[5] : op6_ff;
      pending_ff <= nxt_pending;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      exec_ff              <= K_RSVD;
      latency_anchor_ff    <= 1'b0;
      burst_beats_ff       <= NO_BURST;
      reserved_seen_ff     <= 1'b0;
      sequence_error_ff    <= 1'b0;
      cas_operand_error_ff <= 1'b0;
    end else begin
      exec_ff              <= nxt_exec;
      latency_anchor_ff    <= nxt_anchor;
      burst_beats_ff       <= nxt_beats;
      reserved_seen_ff     <= nxt_reserved;
      sequence_error_ff    <= nxt_seq_err;
      cas_operand_error_ff <= nxt_cas_err;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  AST_CMD_START: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    in_idle && cmd_r1 |=> (state_ff == ST_CMD_R2) && (op6_ff == $past(ca[5])))
    else $error("first edge of command not taken");

  AST_OP6_LOW_NOP: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    in_r2 && !op6_ff |=> (exec_ff == K_NOP) && in_idle)
    else $error("operand bit 6 low did not give no-operation");

  AST_DATA_OP_WAITS: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    in_r2 && ({op6_ff, ca} == OP_WR_FIFO)
    |=> (exec_ff == K_RSVD) && in_wait && (pending_ff == K_WR_FIFO))
    else $error("write-FIFO not held for column command");

  AST_OSC_START: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    in_r2 && ({op6_ff, ca} == OP_OSC_START) |=> exec_ff == K_OSC_START)
    else $error("oscillator start not decoded");

  AST_ZQ_LATCH_ALONE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    in_r2 && ({op6_ff, ca} == OP_ZQ_LATCH)
    |=> (exec_ff == K_ZQ_LATCH) && in_idle ##1 (exec_ff == K_RSVD))
    else $error("calibration latch not a single stand-alone pulse");

  AST_STRAY_CMD: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wait_bad |=> sequence_error_ff && (exec_ff == K_RSVD) && in_idle)
    else $error("command between training op and column command missed");

  AST_ANCHOR: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wait_good |=> in_cas2 ##1 latency_anchor_ff &&
                  (exec_ff == $past(pending_ff)) && is_data_op(exec_ff))
    else $error("latency anchor not on column command second edge");

  AST_STAND_ALONE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (exec_ff != K_RSVD) && !is_data_op(exec_ff) |-> !latency_anchor_ff &&
                                                   $past(in_r2))
    else $error("stand-alone op waited for column command");

  AST_BURST16: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    latency_anchor_ff && is_fifo_op(exec_ff)
    |-> burst_beats_ff == SIXTEEN_BEAT_BURST)
    else $error("FIFO training burst not sixteen beats");

  AST_RESERVED: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    r2_rsvd |=> reserved_seen_ff && (exec_ff == K_RSVD) && in_idle &&
                (pending_ff == $past(pending_ff)))
    else $error("reserved code changed state");

  COV_RD_FIFO: cover property (
    @(posedge clk_sys) disable iff (sys_rst)
    latency_anchor_ff && (exec_ff == K_RD_FIFO));

  COV_ZQ_START: cover property (
    @(posedge clk_sys) disable iff (sys_rst)
    exec_ff == K_ZQ_START);

  COV_SEQ_ERR: cover property (
    @(posedge clk_sys) disable iff (sys_rst)
    sequence_error_ff);

  COV_NOP: cover property (
    @(posedge clk_sys) disable iff (sys_rst)
    exec_ff == K_NOP);

endmodule : dram_multi_purpose_cmd_decoder

// >>> mc_cmd_model.sv
module mc_cmd_model (
  // clock
  input  wire logic       clk_sys,
  // command/address pins
  output logic            cs,
  output logic [5:0]      ca
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_pkg::*;

  initial begin
    cs = 1'b0;
    ca = 6'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-edge training command, operand split across edges
  task automatic send_cmd(input logic [6:0] op);
    @(posedge clk_sys);
    cs <= 1'b1;
    ca <= {op[6], CMD_R1_CA};
    @(posedge clk_sys);
    cs <= 1'b0;
    ca <= op[5:0];
  endtask : send_cmd

  // column command that must follow a data-moving op
  task automatic send_cas(input logic [5:0] r2);
    @(posedge clk_sys);
    cs <= 1'b1;
    ca <= {1'b0, CAS2_R1_CA};
    @(posedge clk_sys);
    cs <= 1'b0;
    ca <= r2;
  endtask : send_cas

  // deselect; bus toggles so a stale value never passes
  task automatic idle();
    @(posedge clk_sys);
    cs <= 1'b0;
    ca <= ~ca;
  endtask : idle

endmodule : mc_cmd_model

// >>> dram_multi_purpose_cmd_decoder_tb.sv
module dram_multi_purpose_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_pkg::*;

  typedef struct packed {
    logic [6:0] op;
    kind_t      k;
    logic       data;
    logic       fifo;
    logic [2:0] flags;
  } row_t;

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cs;
  logic [5:0]  ca;
  kind_t       exec_k;
  logic        anchor;
  logic [4:0]  beats;
  logic        rsv;
  logic        seq_err;
  logic        cas_err;
  wire  [16:0] obs = {exec_k, anchor, beats, rsv, seq_err, cas_err};
  row_t        rows [11];
  logic [16:0] row_exp;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  mc_cmd_model ctl_u (.clk_sys(clk_sys), .cs(cs), .ca(ca));

  dram_multi_purpose_cmd_decoder dut_u (
    .clk_sys              (clk_sys),
    .sys_rst              (sys_rst),
    .cs                   (cs),
    .ca                   (ca),
    .exec_ff              (exec_k),
    .latency_anchor_ff    (anchor),
    .burst_beats_ff       (beats),
    .reserved_seen_ff     (rsv),
    .sequence_error_ff    (seq_err),
    .cas_operand_error_ff (cas_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{7'h15, K_NOP, 1'b0, 1'b0, 3'b000},
             '{OP_RD_FIFO, K_RD_FIFO, 1'b1, 1'b1, 3'b000},
             '{OP_RD_DQ_CAL, K_RD_DQ_CAL, 1'b1, 1'b0, 3'b000},
             '{OP_WR_FIFO, K_WR_FIFO, 1'b1, 1'b1, 3'b000},
             '{OP_OSC_START, K_OSC_START, 1'b0, 1'b0, 3'b000},
             '{OP_OSC_STOP, K_OSC_STOP, 1'b0, 1'b0, 3'b000},
             '{OP_ZQ_START, K_ZQ_START, 1'b0, 1'b0, 3'b000},
             '{OP_ZQ_LATCH, K_ZQ_LATCH, 1'b0, 1'b0, 3'b000},
             '{7'h45, K_RSVD, 1'b0, 1'b0, 3'b100},
             '{7'h49, K_RSVD, 1'b0, 1'b0, 3'b100},
             '{7'h7F, K_RSVD, 1'b0, 1'b0, 3'b100}};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk(obs, 17'h00000);
    foreach (rows[i]) begin
      ctl_u.send_cmd(rows[i].op);
      if (rows[i].data)
        ctl_u.send_cas(6'h00);
      ctl_u.idle();
      row_exp = {rows[i].k, rows[i].data,
                 rows[i].fifo ? SIXTEEN_BEAT_BURST : NO_BURST, rows[i].flags};
      #1 chk(obs, row_exp);
    end
    // deselect gap, then column command with a stray operand bit
    ctl_u.send_cmd(OP_WR_FIFO);
    ctl_u.idle();
    ctl_u.idle();
    ctl_u.send_cas(6'h01);
    ctl_u.idle();
    row_exp = {K_WR_FIFO, 1'b1, SIXTEEN_BEAT_BURST, 3'b001};
    #1 chk(obs, row_exp);
    // another command in place of the column command
    ctl_u.send_cmd(OP_RD_FIFO);
    ctl_u.send_cmd(OP_ZQ_START);
    #1 chk(obs, {K_RSVD, 1'b0, NO_BURST, 3'b010});
    ctl_u.idle();
    #1 chk(obs, 17'h00000);
    // back to back stand-alone ops
    ctl_u.send_cmd(OP_OSC_START);
    fork
      ctl_u.send_cmd(OP_OSC_STOP);
      begin
        @(posedge clk_sys);
        #1 chk(obs, {K_OSC_START, 1'b0, NO_BURST, 3'b000});
      end
    join
    ctl_u.idle();
    #1 chk(obs, {K_OSC_STOP, 1'b0, NO_BURST, 3'b000});
    // reset between a data op and its column command
    ctl_u.send_cmd(OP_RD_FIFO);
    ctl_u.idle();
    sys_rst <= 1'b1;
    ctl_u.idle();
    #1 chk(obs, 17'h00000);
    ctl_u.idle();
    sys_rst <= 1'b0;
    ctl_u.send_cas(6'h00);
    ctl_u.idle();
    #1 chk(obs, 17'h00000);
    results();
  end

endmodule : dram_multi_purpose_cmd_decoder_tb
